/* pfm_pkg.sv */
// Package of constants for the pin function multiplexer
package pfm_pkg;
  // ----------------------------------------------------------------
  // Pin counts and bit positions
  // ----------------------------------------------------------------
  localparam int PFM_P0_W = 8;
  localparam int PFM_P1_W = 7;
  localparam int PFM_P0_NONE = 0;
  localparam int PFM_P0_SEC = 1;
  localparam int PFM_P0_PRI = 2;
  localparam int PFM_P0_CMPO = 3;
  localparam int PFM_P0_VREF = 4;
  localparam int PFM_P0_COMPARATOR_IN_PIN = 5;
  localparam int PFM_P0_INT = 6;
  localparam int PFM_P0_SINK = 7;
  localparam int PFM_P1_TDI = 0;
  localparam int PFM_P1_RST = 1;
  localparam int PFM_P1_TMS = 2;
  localparam int PFM_P1_TCK = 3;
  localparam int PFM_P1_TDO = 4;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PFM_P0_RST = 8'h00;
  localparam logic [6:0] PFM_P1_RST_V = 7'h00;
  localparam logic [7:0] PFM_PU0_RST = 8'hff;
  localparam logic [6:0] PFM_PU1_RST = 7'h7f;
  // Mode of the reset-capable pin
  typedef enum logic {PFM_RSTPIN_RESET, PFM_RSTPIN_PORT} pfm_rstpin_t;
endpackage

/* pfm_sel_if.sv */
// Interface carrying per-pin select and port controls
`timescale 1ns/1ps
`default_nettype none
interface pfm_sel_if;
  import pfm_pkg::*;
  logic [7:0] alt0;
  logic [6:0] alt1;
  logic [7:0] oe0;
  logic [6:0] oe1;
  logic [7:0] pu0;
  logic [6:0] pu1;
  logic rst_pin_port;
  modport ctl (output alt0, alt1, oe0, oe1, pu0, pu1, rst_pin_port);
  modport mux (input alt0, alt1, oe0, oe1, pu0, pu1, rst_pin_port);
endinterface
`default_nettype wire

/* pfm_ctl.sv */
// Control register bank: alternate selects, port enables, pull-ups, reset-pin mode
`timescale 1ns/1ps
`default_nettype none
module pfm_ctl
  import pfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic cfg_we,
  input wire logic [7:0] alt0_d,
  input wire logic [6:0] alt1_d,
  input wire logic [7:0] oe0_d,
  input wire logic [6:0] oe1_d,
  input wire logic [7:0] pu0_d,
  input wire logic [6:0] pu1_d,
  input wire logic reset_pin_disable,
  pfm_sel_if.ctl sel
);
  logic [7:0] alt0_q, oe0_q, pu0_q;
  logic [6:0] alt1_q, oe1_q, pu1_q;
  pfm_rstpin_t rpm_q;

  // [RULE1] port defaults on reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alt0_q <= PFM_P0_RST;
      alt1_q <= PFM_P1_RST_V;
      oe0_q <= PFM_P0_RST;
      oe1_q <= PFM_P1_RST_V;
      pu0_q <= PFM_PU0_RST;
      pu1_q <= PFM_PU1_RST;
    end else if (cfg_we) begin
      alt0_q <= alt0_d;
      alt1_q <= alt1_d;
      oe0_q <= oe0_d;
      oe1_q <= oe1_d;
      pu0_q <= pu0_d;
      pu1_q <= pu1_d;
    end
  end

  // [RULE2] power-on gives reset mode
  // Only power-on restores the reset function; a pin reset must not re-arm itself.
  always_ff @(posedge core_clk or negedge por_b) begin
    if (!por_b) begin
      rpm_q <= PFM_RSTPIN_RESET;
    end else if (reset_pin_disable) begin
      // [RULE3] disable bit releases pin
      rpm_q <= PFM_RSTPIN_PORT;
    end
  end

  assign sel.alt0 = alt0_q;
  assign sel.alt1 = alt1_q;
  assign sel.oe0 = oe0_q;
  assign sel.oe1 = oe1_q;
  assign sel.pu0 = pu0_q;
  assign sel.pu1 = pu1_q;
  assign sel.rst_pin_port = (rpm_q == PFM_RSTPIN_PORT);
endmodule
`default_nettype wire

/* pfm_top.sv */
// Pin function multiplexer top: port and alternate function routing
// Summary of operation
// [RULE1] After reset, shared pins are inputs with pull-up, alternates off.
// [RULE2] After power-on, the reset-capable pin is an active-low reset input.
// [RULE3] Writing one to the disable bit turns the reset pin into port I/O.
// [RULE4] While horn enabled, silver output is the complement of brass output.
// [RULE5] Timer pins carry timer input/output or secondary output, else port bit.
// [RULE6] Debug signals TCK, TMS, TDI, TDO each share a port-one pin.
// [RULE7] Interrupt pin is an edge-selectable interrupt source or port bit.
// [RULE8] Port zero bit seven as driver sinks only low; else normal port.
// [RULE9] Comparator output, input and reference pins serve function or port.
// [RULE10] Per-pin alternate select; port enable and pull-up apply only unselected.
`timescale 1ns/1ps
`default_nettype none
module pfm_top
  import pfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic cfg_we,
  input wire logic [7:0] alt0_sel,
  input wire logic [6:0] alt1_sel,
  input wire logic [7:0] port0_oe,
  input wire logic [6:0] port1_oe,
  input wire logic [7:0] port0_pu,
  input wire logic [6:0] port1_pu,
  input wire logic reset_pin_disable,
  input wire logic [7:0] port0_out,
  input wire logic [6:0] port1_out,
  output logic [7:0] port0_in,
  output logic [6:0] port1_in,
  input wire logic [7:0] pad0_i,
  output logic [7:0] pad0_o,
  output logic [7:0] pad0_oe,
  output logic [7:0] pad0_pu,
  input wire logic [6:0] pad1_i,
  output logic [6:0] pad1_o,
  output logic [6:0] pad1_oe,
  output logic [6:0] pad1_pu,
  input wire logic timer_out,
  input wire logic timer_out_en,
  input wire logic timer_sec_out,
  output logic timer_in,
  input wire logic cmp_result,
  output logic cmp_in_connect,
  output logic vref_connect,
  input wire logic vref_drive_en,
  input wire logic int_edge_fall,
  output logic ext_int_pulse,
  output logic pin_reset_b,
  input wire logic sink_on,
  input wire logic dbg_tdo,
  input wire logic dbg_tdo_en,
  output logic dbg_tck,
  output logic dbg_tms,
  output logic dbg_tdi,
  input wire logic horn_en,
  input wire logic horn_drive,
  output logic horn_brass_out,
  output logic horn_silver_out
);
  pfm_sel_if sel();
  logic [7:0] o0, e0, u0;
  logic [6:0] o1, e1, u1;
  logic int_q, int_prev_q, ext_int_q, tin_q, tck_q, tms_q, tdi_q;
  logic rstpin_q, hb_q, hs_q;
  logic [7:0] p0in_q;
  logic [6:0] p1in_q;

  pfm_ctl pfm_ctl_inst (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .por_b(por_b),
    .cfg_we(cfg_we),
    .alt0_d(alt0_sel),
    .alt1_d(alt1_sel),
    .oe0_d(port0_oe),
    .oe1_d(port1_oe),
    .pu0_d(port0_pu),
    .pu1_d(port1_pu),
    .reset_pin_disable(reset_pin_disable),
    .sel(sel)
  );

  // ----------------------------------------------------------------
  // Port zero routing
  // ----------------------------------------------------------------
  always_comb begin
    // [RULE10] port controls when unselected
    o0 = port0_out;
    e0 = sel.oe0 & ~sel.alt0;
    u0 = sel.pu0 & ~sel.alt0 & ~sel.oe0;
    // [RULE5] timer pins
    if (sel.alt0[PFM_P0_PRI]) begin
      o0[PFM_P0_PRI] = timer_out;
      e0[PFM_P0_PRI] = timer_out_en;
    end
    if (sel.alt0[PFM_P0_SEC]) begin
      o0[PFM_P0_SEC] = timer_sec_out;
      e0[PFM_P0_SEC] = 1'b1;
    end
    // [RULE9] comparator and reference
    if (sel.alt0[PFM_P0_CMPO]) begin
      o0[PFM_P0_CMPO] = cmp_result;
      e0[PFM_P0_CMPO] = 1'b1;
    end
    // Digital buffers stay off on analog pins; reference may be driven out
    if (sel.alt0[PFM_P0_VREF]) begin
      o0[PFM_P0_VREF] = 1'b0;
      e0[PFM_P0_VREF] = 1'b0;
    end
    // [RULE8] sink driver pulls low only
    if (sel.alt0[PFM_P0_SINK]) begin
      o0[PFM_P0_SINK] = 1'b0;
      e0[PFM_P0_SINK] = sink_on;
    end
    // Interrupt and comparator input pins are inputs when selected
    o0[PFM_P0_NONE] = port0_out[PFM_P0_NONE];
  end

  // ----------------------------------------------------------------
  // Port one routing
  // ----------------------------------------------------------------
  always_comb begin
    o1 = port1_out;
    e1 = sel.oe1 & ~sel.alt1;
    u1 = sel.pu1 & ~sel.alt1 & ~sel.oe1;
    // [RULE6] debug output shares pin
    if (sel.alt1[PFM_P1_TDO]) begin
      o1[PFM_P1_TDO] = dbg_tdo;
      e1[PFM_P1_TDO] = dbg_tdo_en;
    end
    // [RULE2] reset pin is input only
    if (!sel.rst_pin_port) begin
      o1[PFM_P1_RST] = 1'b0;
      e1[PFM_P1_RST] = 1'b0;
      u1[PFM_P1_RST] = 1'b1;
    end
  end

  assign pad0_o = o0;
  assign pad0_oe = e0;
  assign pad0_pu = u0;
  assign pad1_o = o1;
  assign pad1_oe = e1;
  assign pad1_pu = u1;
  assign cmp_in_connect = sel.alt0[PFM_P0_COMPARATOR_IN_PIN];
  assign vref_connect = sel.alt0[PFM_P0_VREF] & vref_drive_en;

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      p0in_q <= 8'h00;
      p1in_q <= 7'h00;
      tin_q <= 1'b0;
      tck_q <= 1'b0;
      tms_q <= 1'b0;
      tdi_q <= 1'b0;
    end else begin
      p0in_q <= pad0_i;
      p1in_q <= pad1_i;
      // [RULE5] timer input gated
      tin_q <= sel.alt0[PFM_P0_PRI] & pad0_i[PFM_P0_PRI];
      // [RULE6] debug inputs gated
      tck_q <= sel.alt1[PFM_P1_TCK] & pad1_i[PFM_P1_TCK];
      tms_q <= sel.alt1[PFM_P1_TMS] & pad1_i[PFM_P1_TMS];
      tdi_q <= sel.alt1[PFM_P1_TDI] & pad1_i[PFM_P1_TDI];
    end
  end
  assign port0_in = p0in_q;
  assign port1_in = p1in_q;
  assign timer_in = tin_q;
  assign dbg_tck = tck_q;
  assign dbg_tms = tms_q;
  assign dbg_tdi = tdi_q;

  // ----------------------------------------------------------------
  // External interrupt
  // ----------------------------------------------------------------
  // [RULE7] edge-selectable interrupt
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_q <= 1'b1;
      int_prev_q <= 1'b1;
      ext_int_q <= 1'b0;
    end else begin
      int_q <= pad0_i[PFM_P0_INT];
      int_prev_q <= int_q;
      ext_int_q <= sel.alt0[PFM_P0_INT] &
        (int_edge_fall ? (int_prev_q & ~int_q) : (~int_prev_q & int_q));
    end
  end
  assign ext_int_pulse = ext_int_q;

  // ----------------------------------------------------------------
  // Reset pin and horn
  // ----------------------------------------------------------------
  // [RULE2] active-low reset from pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstpin_q <= 1'b1;
    end else begin
      rstpin_q <= sel.rst_pin_port | pad1_i[PFM_P1_RST];
    end
  end
  assign pin_reset_b = rstpin_q;

  // [RULE4] silver complements brass
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hb_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      hb_q <= horn_en & horn_drive;
      hs_q <= horn_en & ~horn_drive;
    end
  end
  assign horn_brass_out = hb_q;
  assign horn_silver_out = hs_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic horn_en_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      horn_en_q <= 1'b0;
    end else begin
      horn_en_q <= horn_en;
    end
  end

  horn_compl_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE4]
    horn_en_q |-> (horn_silver_out == ~horn_brass_out)) else $error("horn outputs not complementary");
  port_default_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE1]
    $rose(rst_b) |-> (pad0_oe == 8'h00 && pad0_pu == 8'hff)) else $error("port0 not default after reset");
  rst_pin_in_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE2]
    !sel.rst_pin_port |-> (!pad1_oe[PFM_P1_RST] && pad1_pu[PFM_P1_RST])) else $error("reset pin driven");
  rst_release_a: assert property (@(posedge core_clk) disable iff (!rst_b || !por_b) // [RULE3]
    reset_pin_disable |=> sel.rst_pin_port ##1 pin_reset_b) else $error("reset pin not released");
  timer_sec_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE5]
    sel.alt0[PFM_P0_SEC] |-> (pad0_oe[PFM_P0_SEC] && pad0_o[PFM_P0_SEC] == timer_sec_out))
    else $error("secondary timer output wrong");
  dbg_tck_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE6]
    !sel.alt1[PFM_P1_TCK] |=> !dbg_tck) else $error("debug clock leaked from port");
  ext_int_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE7]
    ext_int_pulse |-> $past(sel.alt0[PFM_P0_INT])) else $error("interrupt while deselected");
  sink_low_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE8]
    sel.alt0[PFM_P0_SINK] |-> !pad0_o[PFM_P0_SINK]) else $error("sink driver drove high");
  cmp_out_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE9]
    sel.alt0[PFM_P0_CMPO] |-> (pad0_o[PFM_P0_CMPO] == cmp_result)) else $error("comparator output wrong");
  alt_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE10]
    ((sel.alt0 & pad0_pu) == 8'h00) && ((sel.alt1 & ~8'(1 << PFM_P1_RST) & {1'b0, pad1_pu}) == 8'h00))
    else $error("pull-up on alternate pin");

  horn_on_c: cover property (@(posedge core_clk) disable iff (!rst_b) horn_en_q && horn_brass_out);
  rst_port_c: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(sel.rst_pin_port));
  int_c: cover property (@(posedge core_clk) disable iff (!rst_b) ext_int_pulse);
  sink_c: cover property (@(posedge core_clk) disable iff (!rst_b) pad0_oe[PFM_P0_SINK] && sel.alt0[PFM_P0_SINK]);
endmodule
`default_nettype wire

/* pfm_board.sv */
// Board model: resolves every pad from device drive, board drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module pfm_board (
  input wire logic core_clk,
  input wire logic [7:0] pad0_o,
  input wire logic [7:0] pad0_oe,
  input wire logic [7:0] pad0_pu,
  input wire logic [7:0] ext0,
  input wire logic [7:0] ext0_en,
  input wire logic [6:0] pad1_o,
  input wire logic [6:0] pad1_oe,
  input wire logic [6:0] pad1_pu,
  input wire logic [6:0] ext1,
  input wire logic [6:0] ext1_en,
  output logic [7:0] pad0_i,
  output logic [6:0] pad1_i
);
  // Floating pads toggle each cycle, so no test can lean on a held level
  logic [7:0] flt_q = 8'h00;
  always @(posedge core_clk) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    pad0_i = (pad0_oe & pad0_o) | (~pad0_oe & ext0_en & ext0) | (~pad0_oe & ~ext0_en & (pad0_pu | flt_q));
    pad1_i = (pad1_oe & pad1_o) | (~pad1_oe & ext1_en & ext1) | (~pad1_oe & ~ext1_en & (pad1_pu | flt_q[6:0]));
  end
endmodule
`default_nettype wire

/* test_pin_function_mux.sv */
// Self-checking testbench for the pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module test_pin_function_mux;
  import pfm_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0, por_b = 1'b0, cfg_we = 1'b0, reset_pin_disable = 1'b0;
  logic [7:0] alt0_sel = '0, port0_oe = '0, port0_pu = '0, port0_out = '0, ext0 = '0, ext0_en = '0;
  logic [6:0] alt1_sel = '0, port1_oe = '0, port1_pu = '0, port1_out = '0, ext1 = '0, ext1_en = '0;
  logic timer_out = 1'b0, timer_out_en = 1'b0, timer_sec_out = 1'b0, cmp_result = 1'b0, vref_drive_en = 1'b0;
  logic int_edge_fall = 1'b0, sink_on = 1'b0, dbg_tdo = 1'b0, dbg_tdo_en = 1'b0, horn_en = 1'b0, horn_drive = 1'b0;
  logic [7:0] port0_in, pad0_i, pad0_o, pad0_oe, pad0_pu;
  logic [6:0] port1_in, pad1_i, pad1_o, pad1_oe, pad1_pu;
  logic timer_in, cmp_in_connect, vref_connect, ext_int_pulse, pin_reset_b;
  logic dbg_tck, dbg_tms, dbg_tdi, horn_brass_out, horn_silver_out;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  pfm_top pfm_top_inst (.core_clk(core_clk), .rst_b(rst_b), .por_b(por_b), .cfg_we(cfg_we),
    .alt0_sel(alt0_sel), .alt1_sel(alt1_sel), .port0_oe(port0_oe), .port1_oe(port1_oe),
    .port0_pu(port0_pu), .port1_pu(port1_pu), .reset_pin_disable(reset_pin_disable),
    .port0_out(port0_out), .port1_out(port1_out), .port0_in(port0_in), .port1_in(port1_in),
    .pad0_i(pad0_i), .pad0_o(pad0_o), .pad0_oe(pad0_oe), .pad0_pu(pad0_pu),
    .pad1_i(pad1_i), .pad1_o(pad1_o), .pad1_oe(pad1_oe), .pad1_pu(pad1_pu),
    .timer_out(timer_out), .timer_out_en(timer_out_en), .timer_sec_out(timer_sec_out), .timer_in(timer_in),
    .cmp_result(cmp_result), .cmp_in_connect(cmp_in_connect), .vref_connect(vref_connect),
    .vref_drive_en(vref_drive_en), .int_edge_fall(int_edge_fall), .ext_int_pulse(ext_int_pulse),
    .pin_reset_b(pin_reset_b), .sink_on(sink_on), .dbg_tdo(dbg_tdo), .dbg_tdo_en(dbg_tdo_en),
    .dbg_tck(dbg_tck), .dbg_tms(dbg_tms), .dbg_tdi(dbg_tdi), .horn_en(horn_en), .horn_drive(horn_drive),
    .horn_brass_out(horn_brass_out), .horn_silver_out(horn_silver_out));
  pfm_board pfm_board_inst (.core_clk(core_clk), .pad0_o(pad0_o), .pad0_oe(pad0_oe), .pad0_pu(pad0_pu),
    .ext0(ext0), .ext0_en(ext0_en), .pad1_o(pad1_o), .pad1_oe(pad1_oe), .pad1_pu(pad1_pu),
    .ext1(ext1), .ext1_en(ext1_en), .pad0_i(pad0_i), .pad1_i(pad1_i));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic cfg(input logic [7:0] a0, input logic [6:0] a1, input logic [7:0] o0,
                     input logic [6:0] o1, input logic [7:0] p0, input logic [6:0] p1);
    alt0_sel = a0;
    alt1_sel = a1;
    port0_oe = o0;
    port1_oe = o1;
    port0_pu = p0;
    port1_pu = p1;
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
  endtask
  // Power-on reset only when asked; a plain system reset keeps the reset-pin mode
  task automatic do_reset(input logic with_por);
    rst_b = 1'b0;
    por_b = ~with_por;
    cyc(6);
    rst_b = 1'b1;
    por_b = 1'b1;
    cyc(1);
  endtask
  task automatic count_pulses(output int n);
    n = 0;
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      if (ext_int_pulse === 1'b1) begin
        n++;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_defaults();
    chk(pad0_oe, 8'h00, "pad0 oe");
    chk(pad0_pu, 8'hff, "pad0 pu");
    chk({1'b0, pad1_oe}, 8'h00, "pad1 oe");
    chk({1'b0, pad1_pu}, 8'h7f, "pad1 pu");
    chk({6'h00, cmp_in_connect, vref_connect}, 8'h00, "analog off");
    chk({6'h00, horn_brass_out, horn_silver_out}, 8'h00, "horn off");
    chk_bit(ext_int_pulse, 1'b0, "no interrupt");
    chk_bit(pin_reset_b, 1'b1, "reset idle");
    $display("test defaults finished");
  endtask
  task automatic test_reset_pin();
    cfg(8'h00, 7'h00, 8'h00, 7'h02, 8'h00, 7'h02);
    chk({1'b0, pad1_oe}, 8'h00, "reset pin not driven");
    chk({1'b0, pad1_pu}, 8'h02, "reset pin pull-up");
    ext1_en = 7'h02;
    cyc(2);
    chk_bit(pin_reset_b, 1'b0, "pin reset asserted");
    ext1_en = 7'h00;
    reset_pin_disable = 1'b1;
    cyc(1);
    reset_pin_disable = 1'b0;
    cyc(1);
    chk({1'b0, pad1_oe}, 8'h02, "pin drives as port");
    chk({1'b0, pad1_pu}, 8'h00, "pull-up off while driving");
    chk_bit(pin_reset_b, 1'b1, "low port drive no reset");
    do_reset(1'b0);
    ext1_en = 7'h02;
    cyc(2);
    chk_bit(pin_reset_b, 1'b1, "port mode survives reset");
    ext1_en = 7'h00;
    do_reset(1'b1);
    ext1_en = 7'h02;
    cyc(2);
    chk_bit(pin_reset_b, 1'b0, "power-on re-arms reset");
    ext1_en = 7'h00;
    cyc(2);
    $display("test reset_pin finished");
  endtask
  task automatic test_port();
    port0_out = 8'ha5;
    cfg(8'h00, 7'h00, 8'h3c, 7'h00, 8'hff, 7'h00);
    cyc(1);
    chk(pad0_oe, 8'h3c, "port oe");
    chk(pad0_pu, 8'hc3, "pull-up only undriven");
    chk(pad0_o & 8'h3c, 8'h24, "port data");
    chk(port0_in, 8'he7, "port input sample");
    $display("test port finished");
  endtask
  task automatic test_alt();
    {timer_out, timer_out_en, timer_sec_out, cmp_result, sink_on, dbg_tdo, dbg_tdo_en, vref_drive_en} = 8'hff;
    port0_out = 8'h00;
    cfg(8'hfe, 7'h1f, 8'hff, 7'h7f, 8'hff, 7'h7f);
    chk(pad0_oe & 8'hcf, 8'h8f, "alt0 enables");
    chk(pad0_o & 8'hcf, 8'h0e, "alt0 data");
    chk(pad0_pu, 8'h00, "alt0 pull-ups");
    chk({1'b0, pad1_oe}, 8'h70, "alt1 enables");
    chk({1'b0, pad1_o & 7'h10}, 8'h10, "tdo drive");
    chk({6'h00, cmp_in_connect, vref_connect}, 8'h03, "analog on");
    sink_on = 1'b0;
    timer_out_en = 1'b0;
    ext0 = 8'h04;
    ext0_en = 8'h04;
    ext1 = 7'h08;
    ext1_en = 7'h0d;
    cyc(2);
    chk(pad0_oe & 8'h84, 8'h00, "sink and timer off");
    chk_bit(timer_in, 1'b1, "timer input");
    chk({5'h00, dbg_tck, dbg_tms, dbg_tdi}, 8'h04, "debug inputs");
    chk({1'b0, port1_in}, 8'h1a, "port1 input sample");
    {ext0_en, ext1_en} = 15'h0000;
    $display("test alt finished");
  endtask
  task automatic test_int();
    int n;
    ext0 = 8'h40;
    ext0_en = 8'h40;
    int_edge_fall = 1'b1;
    cfg(8'h40, 7'h00, 8'h00, 7'h00, 8'h00, 7'h00);
    cyc(6);
    ext0 = 8'h00;
    count_pulses(n);
    chk(8'(n), 8'h01, "falling edge pulse");
    ext0 = 8'h40;
    count_pulses(n);
    chk(8'(n), 8'h00, "rising ignored");
    int_edge_fall = 1'b0;
    ext0 = 8'h00;
    count_pulses(n);
    chk(8'(n), 8'h00, "falling ignored");
    ext0 = 8'h40;
    count_pulses(n);
    chk(8'(n), 8'h01, "rising edge pulse");
    $display("test int finished");
  endtask
  task automatic test_horn();
    horn_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      horn_drive = i[0];
      cyc(1);
      chk({6'h00, horn_brass_out, horn_silver_out}, {6'h00, i[0], ~i[0]}, "horn pair");
    end
    horn_en = 1'b0;
    cyc(1);
    chk({6'h00, horn_brass_out, horn_silver_out}, 8'h00, "horn disabled");
    $display("test horn finished");
  endtask
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    test_defaults();
    test_reset_pin();
    test_port();
    test_alt();
    test_int();
    test_horn();
    complete_run();
  end
endmodule
`default_nettype wire
